// ==== dgt_ctrl.sv ====
// Controller end: drives the link clock from a divider and the command pins.
// Assumes software uses the plain port; read data one cycle after strobe.
`timescale 1ns/1ps
`include "dgt_regs.svh"
module dgt_ctrl (
   input wire logic clk,
   input wire logic reset,
   dgt_if.ctrl pins,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata_q
);
   logic [3:0] div_q;
   logic ck_q;
   logic [3:0] ctrl_q;
   logic [15:0] addr_q;
   logic [3:0] cmd_q;
   logic cmd_pend_q;
   logic [15:0] wdata_q;
   logic [15:0] dq_s1_q;
   logic [15:0] dq_s2_q;
   logic [1:0] rd_cnt_q;
   logic [15:0] rd_cap_q;
   logic busy;
   assign busy = cmd_pend_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_q <= 4'h0;
         ck_q <= 1'b0;
      end else if (div_q == 4'(`DGT_CK_HALF - 1)) begin
         div_q <= 4'h0;
         ck_q <= ~ck_q;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= `DGT_CTRL_RST;
         addr_q <= 16'h0000;
         wdata_q <= 16'h0000;
         cmd_q <= 4'h7;
         cmd_pend_q <= 1'b0;
      end else begin
         if (wr && addr == `DGT_OFF_CTRL) begin
            ctrl_q <= wdata[3:0];
         end
         if (wr && addr == `DGT_OFF_ADDR) begin
            addr_q <= wdata;
         end
         if (wr && addr == `DGT_OFF_WDATA) begin
            // Half width keeps the upper lane quiet.
            wdata_q <= ctrl_q[`DGT_CTRL_HALF] ? {8'h00, wdata[7:0]} : wdata;
         end
         if (wr && addr == `DGT_OFF_CMD) begin
            cmd_q <= wdata[3:0];
            cmd_pend_q <= 1'b1;
         end else if (cmd_pend_q && div_q == 4'(`DGT_CK_HALF - 1) && ck_q) begin
            cmd_pend_q <= 1'b0;
         end
      end
   end
   // Command, address, mask and data pins change on the falling link edge so the far end sees them settled.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pins.ck <= 1'b0;
         pins.ck_n <= 1'b1;
         pins.cke <= 1'b0;
         pins.odt <= 1'b0;
         pins.cs_n <= 1'b1;
         pins.ras_n <= 1'b1;
         pins.cas_n <= 1'b1;
         pins.we_n <= 1'b1;
         pins.ba <= 2'h0;
         pins.a <= 14'h0000;
         pins.dm <= 2'h0;
         pins.dq_c <= 16'h0000;
         pins.dq_c_oe <= 1'b0;
      end else begin
         // The pin takes the divider's next value, so it falls as the command changes.
         pins.ck <= (div_q == 4'(`DGT_CK_HALF - 1)) ? ~ck_q : ck_q;
         pins.ck_n <= (div_q == 4'(`DGT_CK_HALF - 1)) ? ck_q : ~ck_q;
         // Clock enable may not drop while an access is pending.
         pins.cke <= ctrl_q[`DGT_CTRL_CKE] | busy;
         pins.odt <= ctrl_q[`DGT_CTRL_ODT];
         if (div_q == 4'(`DGT_CK_HALF - 1) && ck_q) begin
            if (cmd_pend_q) begin
               {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= cmd_q;
            end else begin
               {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h7;
            end
            pins.ba <= addr_q[15:14];
            pins.a <= addr_q[13:0];
            pins.dm <= ctrl_q[`DGT_CTRL_HALF] ? {1'b1, ctrl_q[`DGT_CTRL_MASK]}
               : {2{ctrl_q[`DGT_CTRL_MASK]}};
            pins.dq_c <= wdata_q;
            pins.dq_c_oe <= cmd_pend_q && cmd_q == 4'h4;
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dq_s1_q <= 16'h0000;
         dq_s2_q <= 16'h0000;
      end else begin
         dq_s1_q <= pins.dq;
         dq_s2_q <= dq_s1_q;
      end
   end
   // The burst is gone long before software can poll, so it is caught two link periods on.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_cnt_q <= 2'h0;
         rd_cap_q <= 16'h0000;
      end else if (div_q == 4'(`DGT_CK_HALF - 1) && ck_q) begin
         if (cmd_pend_q && cmd_q == 4'h5) begin
            rd_cnt_q <= 2'h2;
         end else if (rd_cnt_q != 2'h0) begin
            rd_cnt_q <= rd_cnt_q - 2'h1;
            if (rd_cnt_q == 2'h1) begin
               rd_cap_q <= dq_s2_q;
            end
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 16'h0000;
      end else if (rd) begin
         case (addr)
            `DGT_OFF_CTRL: rdata_q <= {12'h000, ctrl_q};
            `DGT_OFF_ADDR: rdata_q <= addr_q;
            `DGT_OFF_STAT: rdata_q <= {15'h0000, busy};
            `DGT_OFF_RDATA: rdata_q <= ctrl_q[`DGT_CTRL_HALF] ? {8'h00, rd_cap_q[7:0]} : rd_cap_q;
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end
endmodule : dgt_ctrl

// ==== dgt_if.sv ====
// Pin-level link between the controller and the memory front end.
// The interface resolves the two-way data wire from the enables.
`timescale 1ns/1ps
interface dgt_if;
   logic ck;
   logic ck_n;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] ba;
   logic [13:0] a;
   logic odt;
   logic [15:0] dq_c;
   logic dq_c_oe;
   logic [15:0] dq_m;
   logic dq_m_oe;
   logic [1:0] dm;
   logic rstrobe;
   logic rstrobe_oe;
   logic [15:0] dq;
   assign dq = dq_c_oe ? dq_c : (dq_m_oe ? dq_m : 16'h0000);
   modport ctrl (output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, a, odt,
      dq_c, dq_c_oe, dm, input dq, rstrobe, rstrobe_oe);
   modport mem (input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, a, odt, dq, dm,
      output dq_m, dq_m_oe, rstrobe, rstrobe_oe);
endinterface : dgt_if

// ==== dgt_link_sva.sv ====
// Checker of the link pins between the controller end and the memory end.
// Assumes the bench instantiates it beside the interface, connected by name.
`timescale 1ns/1ps
module dgt_link_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic ck,
   input wire logic ck_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic dq_c_oe,
   input wire logic dq_m_oe,
   input wire logic rstrobe_oe
);
   logic [3:0] cmd;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   ck_pair_a: assert property (ck_n == !ck)
      else $error("ck_n is not the inverse of ck");
   ck_high_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
      else $error("link clock high half is not four clocks");
   ck_low_a: assert property ($fell(ck) |-> !ck [*4] ##1 ck)
      else $error("link clock low half is not four clocks");
   // Leaving the reset pattern is exempt, since it need not meet a clock fall.
   cmd_edge_a: assert property ($changed(cmd) && $past(cmd) != 4'hf |-> $fell(ck))
      else $error("command pins moved away from a link clock fall");
   cmd_hold_a: assert property ($changed(cmd) && $past(cmd) != 4'hf |=> $stable(cmd) [*7])
      else $error("command pins did not stand one link period");
   access_cke_a: assert property ($rose(ck) && cmd inside {4'h4, 4'h5} |-> cke)
      else $error("clock enable low during an access");
   rd_drive_a: assert property ($rose(ck) && cmd == 4'h5 && cke |-> ##[1:64] dq_m_oe)
      else $error("read command got no read data");
   drv_cke_a: assert property (dq_m_oe |-> cke)
      else $error("memory drives data while clock enable is low");
   rstrobe_a: assert property (rstrobe_oe |-> dq_m_oe)
      else $error("read strobe driven without read data");
   bus_excl_a: assert property (!(dq_c_oe && dq_m_oe))
      else $error("both ends drive the data wire");
endmodule : dgt_link_sva

// ==== dgt_mem.sv ====
// Memory end: samples command pins on the clock crossing, gates power states.
// Assumes the link clock is slow against clk; all link pins are synchronised.
// Behaviour
// - Capture inputs at rising true clock crossing
// - Read data timed on both clock crossings
// - Clock enable high runs internals; low stops
// - Idle banks: precharge power-down or self refresh
// - Clock enable sampled on crossings for power-down
// - Self refresh exit on clock enable asynchronously
// - Controller holds clock enable high during access; ours holds it only until the command reaches the pins
// - Power-down keeps only clock, termination, enable
// - Self refresh keeps only clock enable input
// - Commands ignored while chip select high
// - Chip select is part of command code
// - Termination on when control registered high
// - Termination only on data, strobes, masks
// - Termination ignored when disabled by mode register
// - Read strobe mirrors data strobe; masking off
// - Mode register picks mask or read strobe
// - Half width uses lower byte lanes
// - Command from row, column, write, select
// - Masked write beats are discarded
// - One mode bit disables complementary strobes
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "dgt_regs.svh"
module dgt_mem #(
   parameter int ROWS = 16
) (
   input wire logic clk,
   input wire logic reset,
   dgt_if.mem pins,
   output logic term_on_q,
   output logic [1:0] power_q,
   output logic in_buf_on_q,
   output logic ck_buf_on_q,
   output logic nstrobe_on_q,
   output logic rstrobe_mode_q
);
   logic [1:0] ck_s_q;
   logic ck_prev_q;
   logic [1:0] cke_s_q;
   logic [1:0] odt_s_q;
   logic [1:0] cs_s_q;
   logic [1:0] ras_s_q;
   logic [1:0] cas_s_q;
   logic [1:0] we_s_q;
   logic [1:0] ba0_s_q;
   logic [1:0] ba1_s_q;
   logic [13:0] a_s1_q;
   logic [13:0] a_s2_q;
   logic [15:0] dq_s1_q;
   logic [15:0] dq_s2_q;
   logic [1:0] dm_s1_q;
   logic [1:0] dm_s2_q;
   logic ck_rise;
   logic ck_fall;
   logic [3:0] bank_open_q;
   logic odt_en_q;
   logic [15:0] mem_q [ROWS];
   logic [13:0] col_q;
   logic rd_pend_q;
   logic [1:0] rd_beat_q;
   dgt_pkg::dgt_cmd_t cmd;
   logic cmd_live;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ck_s_q <= 2'h0;
         ck_prev_q <= 1'b0;
         cke_s_q <= 2'h0;
         odt_s_q <= 2'h0;
         cs_s_q <= 2'h3;
         ras_s_q <= 2'h3;
         cas_s_q <= 2'h3;
         we_s_q <= 2'h3;
         ba0_s_q <= 2'h0;
         ba1_s_q <= 2'h0;
         a_s1_q <= 14'h0000;
         a_s2_q <= 14'h0000;
         dq_s1_q <= 16'h0000;
         dq_s2_q <= 16'h0000;
         dm_s1_q <= 2'h0;
         dm_s2_q <= 2'h0;
      end else begin
         ck_s_q <= {ck_s_q[0], pins.ck};
         ck_prev_q <= ck_s_q[1];
         cke_s_q <= {cke_s_q[0], pins.cke};
         odt_s_q <= {odt_s_q[0], pins.odt};
         cs_s_q <= {cs_s_q[0], pins.cs_n};
         ras_s_q <= {ras_s_q[0], pins.ras_n};
         cas_s_q <= {cas_s_q[0], pins.cas_n};
         we_s_q <= {we_s_q[0], pins.we_n};
         ba0_s_q <= {ba0_s_q[0], pins.ba[0]};
         ba1_s_q <= {ba1_s_q[0], pins.ba[1]};
         a_s1_q <= pins.a;
         a_s2_q <= a_s1_q;
         dq_s1_q <= pins.dq;
         dq_s2_q <= dq_s1_q;
         dm_s1_q <= pins.dm;
         dm_s2_q <= dm_s1_q;
      end
   end
   assign ck_rise = ck_s_q[1] & ~ck_prev_q;
   assign ck_fall = ~ck_s_q[1] & ck_prev_q;
   // Chip select high turns every code into a deselect.
   assign cmd = dgt_pkg::dgt_cmd_t'({cs_s_q[1], ras_s_q[1], cas_s_q[1], we_s_q[1]});
   assign cmd_live = ck_rise && !cs_s_q[1] && power_q == dgt_pkg::DGT_PW_RUN;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         power_q <= dgt_pkg::DGT_PW_RUN;
      end else if (power_q == dgt_pkg::DGT_PW_SELF) begin
         // Exit needs no clock crossing; a still link clock must not trap us.
         if (cke_s_q[1]) begin
            power_q <= dgt_pkg::DGT_PW_RUN;
         end
      end else if (ck_rise) begin
         if (power_q == dgt_pkg::DGT_PW_RUN && !cke_s_q[1]) begin
            if (bank_open_q != 4'h0) begin
               power_q <= dgt_pkg::DGT_PW_ACTPD;
            end else if (!cs_s_q[1] && cmd == dgt_pkg::DGT_CMD_REF) begin
               power_q <= dgt_pkg::DGT_PW_SELF;
            end else begin
               power_q <= dgt_pkg::DGT_PW_PREPD;
            end
         end else if (power_q != dgt_pkg::DGT_PW_RUN && cke_s_q[1]) begin
            power_q <= dgt_pkg::DGT_PW_RUN;
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         in_buf_on_q <= 1'b1;
         ck_buf_on_q <= 1'b1;
      end else begin
         in_buf_on_q <= power_q == dgt_pkg::DGT_PW_RUN;
         ck_buf_on_q <= power_q != dgt_pkg::DGT_PW_SELF;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bank_open_q <= 4'h0;
      end else if (cmd_live) begin
         if (cmd == dgt_pkg::DGT_CMD_ACT) begin
            bank_open_q[{ba1_s_q[1], ba0_s_q[1]}] <= 1'b1;
         end else if (cmd == dgt_pkg::DGT_CMD_PRE) begin
            if (a_s2_q[10]) begin
               bank_open_q <= 4'h0;
            end else begin
               bank_open_q[{ba1_s_q[1], ba0_s_q[1]}] <= 1'b0;
            end
         end
      end
   end
   // Extended mode load: bank address one selects the extended register.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         odt_en_q <= 1'b1;
         rstrobe_mode_q <= 1'b0;
         nstrobe_on_q <= 1'b1;
      end else if (cmd_live && cmd == dgt_pkg::DGT_CMD_MRS && ba0_s_q[1] && !ba1_s_q[1]) begin
         odt_en_q <= !a_s2_q[`DGT_EMR_ODT_OFF];
         rstrobe_mode_q <= a_s2_q[`DGT_EMR_RSTROBE];
         nstrobe_on_q <= !a_s2_q[`DGT_EMR_NSTROBE_OFF];
      end
   end
   // Termination control stays live in power-down but not in self refresh.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         term_on_q <= 1'b0;
      end else if (!odt_en_q || power_q == dgt_pkg::DGT_PW_SELF) begin
         term_on_q <= 1'b0;
      end else if (ck_rise) begin
         term_on_q <= odt_s_q[1];
      end
   end
   // Data path: one beat per crossing; the whole word is driven, and a half-width
   // controller clears the upper byte on its own side.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         col_q <= 14'h0000;
         rd_pend_q <= 1'b0;
         rd_beat_q <= 2'h0;
      end else if (cmd_live && cmd == dgt_pkg::DGT_CMD_RD) begin
         col_q <= a_s2_q;
         rd_pend_q <= 1'b1;
         rd_beat_q <= 2'h0;
      end else if (rd_pend_q && (ck_rise || ck_fall)) begin
         rd_beat_q <= rd_beat_q + 2'h1;
         if (rd_beat_q == 2'h1) begin
            rd_pend_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (cmd_live && cmd == dgt_pkg::DGT_CMD_WR) begin
         for (int b = 0; b < 2; b++) begin
            // Read strobe mode reuses the mask pin, so masking is off there.
            if (!(dm_s2_q[b] && !rstrobe_mode_q)) begin
               mem_q[a_s2_q[3:0]][8*b +: 8] <= dq_s2_q[8*b +: 8];
            end
         end
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pins.dq_m <= 16'h0000;
         pins.dq_m_oe <= 1'b0;
         pins.rstrobe <= 1'b0;
         pins.rstrobe_oe <= 1'b0;
      end else begin
         pins.dq_m_oe <= rd_pend_q;
         pins.dq_m <= mem_q[col_q[3:0]];
         pins.rstrobe_oe <= rd_pend_q && rstrobe_mode_q;
         pins.rstrobe <= rd_pend_q && rstrobe_mode_q && ck_s_q[1];
      end
   end
endmodule : dgt_mem

// ==== dgt_pkg.sv ====
// Types used by the memory end of the memory front-end link.
// Assumes dgt_regs.svh is on the include path.
`include "dgt_regs.svh"
package dgt_pkg;
   // Command code: select low, row strobe, column strobe, write enable.
   typedef enum logic [3:0] {
      DGT_CMD_MRS = 4'h0,
      DGT_CMD_REF = 4'h1,
      DGT_CMD_PRE = 4'h2,
      DGT_CMD_ACT = 4'h3,
      DGT_CMD_WR = 4'h4,
      DGT_CMD_RD = 4'h5,
      DGT_CMD_NOP = 4'h7,
      DGT_CMD_DESEL = 4'h8
   } dgt_cmd_t;
   typedef enum logic [1:0] {
      DGT_PW_RUN = 2'h0,
      DGT_PW_PREPD = 2'h1,
      DGT_PW_ACTPD = 2'h2,
      DGT_PW_SELF = 2'h3
   } dgt_pw_t;
endpackage : dgt_pkg

// ==== dgt_regs.svh ====
// Constants shared by both ends of the memory front-end link.
// Assumes inclusion by bare name from the package and the end modules.
`ifndef DGT_REGS_SVH
`define DGT_REGS_SVH
`define DGT_ADDR_W 14
`define DGT_BA_W 2
`define DGT_DQ_W 16
// Controller register offsets.
`define DGT_OFF_CMD 4'h0
`define DGT_OFF_ADDR 4'h1
`define DGT_OFF_CTRL 4'h2
`define DGT_OFF_STAT 4'h3
`define DGT_OFF_WDATA 4'h4
`define DGT_OFF_RDATA 4'h5
// Control register fields.
`define DGT_CTRL_CKE 0
`define DGT_CTRL_ODT 1
`define DGT_CTRL_HALF 2
`define DGT_CTRL_MASK 3
`define DGT_CTRL_RST 4'h0
// Extended mode register bits taken from the address on a load.
`define DGT_EMR_ODT_OFF 0
`define DGT_EMR_RSTROBE 11
`define DGT_EMR_NSTROBE_OFF 10
// Link clock divider half period in system clocks.
`define DGT_CK_HALF 4
`endif

// ==== testbench.sv ====
// Bench joining the controller and memory ends over the link interface.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata_q;
   logic term_on_q, in_buf_on_q, ck_buf_on_q, nstrobe_on_q, rstrobe_mode_q;
   logic [1:0] power_q;
   int err_total = 0;
   int total_checks = 0;
   dgt_if pins ();
   always #20 clk = ~clk;
   dgt_ctrl i_dgt_ctrl (.clk(clk), .reset(reset), .pins(pins), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata_q(rdata_q));
   dgt_mem #(.ROWS(16)) i_dgt_mem (.clk(clk), .reset(reset), .pins(pins),
      .term_on_q(term_on_q), .power_q(power_q), .in_buf_on_q(in_buf_on_q),
      .ck_buf_on_q(ck_buf_on_q), .nstrobe_on_q(nstrobe_on_q), .rstrobe_mode_q(rstrobe_mode_q));
   dgt_link_sva i_dgt_link_sva (.clk(clk), .reset(reset), .ck(pins.ck), .ck_n(pins.ck_n),
      .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
      .we_n(pins.we_n), .dq_c_oe(pins.dq_c_oe), .dq_m_oe(pins.dq_m_oe),
      .rstrobe_oe(pins.rstrobe_oe));
   task automatic final_report();
      if (err_total == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata_q;
      @(posedge clk);
   endtask : reg_rd
   task automatic idle();
      logic [15:0] s;
      for (int i = 0; i < 40; i++) begin
         reg_rd(4'h3, s);
         if (s[0] === 1'b0) return;
      end
      check("busy", 16'h1, 16'h0);
      final_report();
   endtask : idle
   task automatic cmd(input logic [3:0] c, input logic [15:0] ad);
      reg_wr(4'h1, ad);
      reg_wr(4'h0, {12'h000, c});
      idle();
      tick(16);
   endtask : cmd
   task automatic wait_pin(input logic [3:0] c);
      for (int i = 0; i < 40; i++) begin
         tick(1);
         if ({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} === c) return;
      end
      check("pins", 16'h1, 16'h0);
      final_report();
   endtask : wait_pin
   task automatic wait_rise();
      logic last;
      last = 1'b1;
      for (int i = 0; i < 40; i++) begin
         tick(1);
         if (pins.ck === 1'b1 && last === 1'b0) return;
         last = pins.ck;
      end
      check("ck", 16'h1, 16'h0);
      final_report();
   endtask : wait_rise
   task automatic pw(input logic [15:0] ctl, input logic [15:0] p);
      reg_wr(4'h2, ctl);
      tick(20);
      check("power", 16'(power_q), p);
   endtask : pw
   task automatic xfer(input logic [15:0] wd, input logic [15:0] exp);
      logic [15:0] d;
      reg_wr(4'h4, wd);
      cmd(4'h4, 16'h0001);
      cmd(4'h5, 16'h0001);
      tick(16);
      reg_rd(4'h5, d);
      check("rdata", d, exp);
   endtask : xfer
   task automatic s_reset();
      repeat (11) @(posedge clk);
      #1;
      check("power", 16'(power_q), 16'h0);
      check("nstrobe", 16'(nstrobe_on_q), 16'h1);
      @(posedge clk);
      reset <= 1'b0;
      tick(20);
      check("power", 16'(power_q), 16'h1);
      check("in_buf", 16'(in_buf_on_q), 16'h0);
      check("ck_buf", 16'(ck_buf_on_q), 16'h1);
   endtask : s_reset
   task automatic s_power();
      pw(16'h1, 16'h0);
      check("in_buf", 16'(in_buf_on_q), 16'h1);
      cmd(4'h3, 16'h0005);
      pw(16'h0, 16'h2);
      check("in_buf", 16'(in_buf_on_q), 16'h0);
      pw(16'h1, 16'h0);
      cmd(4'h2, 16'h0400);
      // A deselected activate must leave every bank idle.
      cmd(4'hb, 16'h0005);
      pw(16'h0, 16'h1);
      pw(16'h1, 16'h0);
   endtask : s_power
   task automatic s_self();
      reg_wr(4'h1, 16'h0000);
      reg_wr(4'h0, 16'h0001);
      wait_pin(4'h1);
      // Clock enable drops while refresh stands, so both meet one crossing.
      pw(16'h0, 16'h3);
      check("in_buf", 16'(in_buf_on_q), 16'h0);
      check("ck_buf", 16'(ck_buf_on_q), 16'h0);
      wait_rise();
      reg_wr(4'h2, 16'h0001);
      tick(4);
      check("power", 16'(power_q), 16'h0);
   endtask : s_self
   task automatic s_odt();
      pw(16'h3, 16'h0);
      check("term", 16'(term_on_q), 16'h1);
      cmd(4'h0, 16'h4c01);
      check("term", 16'(term_on_q), 16'h0);
      check("rstrobe", 16'(rstrobe_mode_q), 16'h1);
      check("nstrobe", 16'(nstrobe_on_q), 16'h0);
      cmd(4'h0, 16'h4000);
      check("term", 16'(term_on_q), 16'h1);
      check("nstrobe", 16'(nstrobe_on_q), 16'h1);
   endtask : s_odt
   task automatic s_data();
      cmd(4'h3, 16'h0005);
      xfer(16'ha5c3, 16'ha5c3);
      reg_wr(4'h2, 16'h0009);
      xfer(16'h1234, 16'ha5c3);
      cmd(4'h2, 16'h0400);
      cmd(4'h0, 16'h4800);
      cmd(4'h3, 16'h0005);
      xfer(16'h1234, 16'h1234);
      reg_wr(4'h2, 16'h0005);
      xfer(16'hbeef, 16'h00ef);
   endtask : s_data
   initial begin
      s_reset();
      s_power();
      s_self();
      s_odt();
      s_data();
      final_report();
   end
endmodule : testbench
